//--- hdl/ssx_pkg.sv
// Operation
// - Indexed-to-indexed move: 6 cycles, 3 words; indirect source: 5, 2.
// - Bit-clear zero to indexed: 4 cycles, 2 words; jump-next: 2, 1.
// - Bit-clear zero to a register takes 1 cycle and 1 word.
// - Watchdog control write without the key raises a violation.
// - Pop reads top word, adds two to stack pointer, writes target.
// - Byte pop moves low byte; register target gets upper byte zero.
// - Pop always raises the stack pointer by two, word or byte.
// - Push lowers stack pointer by two, then stores source at new top.
// - Push always lowers the stack pointer by two, word or byte.
// - Pop, push, subroutine exit leave flags and mode bits unchanged.
// - Subroutine exit loads counter from top word, then adds two to stack pointer.
// - Interrupt exit restores status word, pops, loads counter, pops.
// - Interrupt exit restores four flags and three mode bits from stack.
// - Arithmetic left shift: bits move up, old top to carry, zero in.
// - Word shift overflow set when 04000h <= operand < 0C000h.
// - Byte shift overflow set when 040h <= operand < 0C0h.
// - Rotate through carry: bits move up, old carry in, top to carry.
// - Rotate overflow set when 03FFFh<op<0C000h, or 03Fh<op<0C0h bytes.
// - After shift or rotate, negative is sign; zero flag on zero result.
// - Byte shift or rotate into a register clears its upper byte.
// - Idle operation only advances program counter; flags untouched.
package ssx_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int         AXI_AW       = 8;
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_SRC      = 8'h08;
  localparam logic [7:0] REG_DST      = 8'h0C;
  localparam logic [7:0] REG_STACK    = 8'h10;
  localparam logic [7:0] REG_STATUSW  = 8'h14;
  localparam logic [7:0] REG_PROG     = 8'h18;
  localparam logic [7:0] REG_RESULT   = 8'h1C;
  localparam logic [7:0] REG_MADDR    = 8'h20;
  localparam logic [7:0] REG_MDATA    = 8'h24;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_OP_LSB    = 0;
  localparam int CTRL_BYTE_BIT  = 4;
  localparam int CTRL_DREG_BIT  = 5;
  localparam int CTRL_START_BIT = 31;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_DONE_BIT  = 1;
  localparam int STAT_VIOL_BIT  = 2;
  localparam int SR_C   = 0;
  localparam int SR_Z   = 1;
  localparam int SR_N   = 2;
  localparam int SR_GIE = 3;
  localparam int SR_CPU = 4;
  localparam int SR_OSC = 5;
  localparam int SR_V   = 8;

  // ----------------------------------------------------------------
  // Datapath constants
  // ----------------------------------------------------------------
  localparam logic [15:0] STACK_STEP   = 16'h0002;
  localparam logic [15:0] WORD_STEP    = 16'h0002;
  localparam logic [15:0] RLA_W_LO     = 16'h4000;
  localparam logic [15:0] RLA_W_HI     = 16'hC000;
  localparam logic [15:0] RLC_W_ABOVE  = 16'h3FFF;
  localparam logic [15:0] RLC_W_BELOW  = 16'hC000;
  localparam logic [7:0]  RLA_B_LO     = 8'h40;
  localparam logic [7:0]  RLA_B_HI     = 8'hC0;
  localparam logic [7:0]  RLC_B_ABOVE  = 8'h3F;
  localparam logic [7:0]  RLC_B_BELOW  = 8'hC0;
  localparam logic [15:0] WDOG_CTRL_ADDR = 16'h0120;
  localparam int          DMEM_AW      = 7;
  localparam int          DMEM_DEPTH   = 128;

  typedef enum logic [3:0] {
    OP_IDLE, OP_POP, OP_PUSH, OP_SUB_EXIT, OP_IRQ_EXIT, OP_SHL_ARITH,
    OP_ROL_CARRY, OP_MOV_XX, OP_MOV_IX, OP_BIC_X, OP_JMP_NEXT, OP_BIC_R
  } ssx_op_type;

  typedef struct packed {
    logic n;
    logic z;
    logic c;
    logic v;
  } ssx_flags_type;

  typedef struct packed {
    logic        aw_have;
    logic [7:0]  awaddr;
    logic        w_have;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    ssx_op_type  op;
    logic        byte_op;
    logic        dst_reg;
    logic        busy;
    logic        done;
    logic        viol;
    logic [2:0]  cnt;
    logic [15:0] src;
    logic [15:0] dst;
    logic [15:0] sp;
    logic [15:0] sr;
    logic [15:0] pc;
    logic [15:0] result;
    logic [15:0] maddr;
  } ssx_state_type;

  // Execution cycles per operation
  function automatic logic [2:0] op_cycles(input ssx_op_type op);
    case (op)
      OP_MOV_XX:   op_cycles = 3'h6;
      OP_MOV_IX:   op_cycles = 3'h5;
      OP_BIC_X:    op_cycles = 3'h4;
      OP_JMP_NEXT: op_cycles = 3'h2;
      OP_IRQ_EXIT: op_cycles = 3'h5;
      OP_SUB_EXIT: op_cycles = 3'h3;
      OP_POP:      op_cycles = 3'h2;
      OP_PUSH:     op_cycles = 3'h3;
      default:     op_cycles = 3'h1;
    endcase
  endfunction

  // Code words per operation
  function automatic logic [1:0] op_words(input ssx_op_type op);
    case (op)
      OP_MOV_XX: op_words = 2'h3;
      OP_MOV_IX: op_words = 2'h2;
      OP_BIC_X:  op_words = 2'h2;
      default:   op_words = 2'h1;
    endcase
  endfunction

endpackage

//--- hdl/ssx_shift_unit.sv
module ssx_shift_unit
  import ssx_pkg::*;
(
  // Operand
  input  wire logic [15:0]   operand,
  input  wire logic          carry_in,
  input  wire logic          byte_op,
  input  wire logic          rotate,
  // Result
  output logic [15:0]        result,
  output ssx_flags_type      flags
);

  logic [7:0]  lo;
  logic        ins;

  always_comb begin
    lo  = operand[7:0];
    ins = rotate ? carry_in : 1'b0;
    flags = '0;
    if (byte_op) begin
      result  = {8'h00, lo[6:0], ins};
      flags.c = lo[7];
      flags.n = result[7];
      flags.z = (result[7:0] == 8'h00);
      if (rotate)
        flags.v = (lo > RLC_B_ABOVE) && (lo < RLC_B_BELOW);
      else
        flags.v = (lo >= RLA_B_LO) && (lo < RLA_B_HI);
    end else begin
      result  = {operand[14:0], ins};
      flags.c = operand[15];
      flags.n = result[15];
      flags.z = (result == 16'h0000);
      if (rotate)
        flags.v = (operand > RLC_W_ABOVE) &&
                  (operand < RLC_W_BELOW);
      else
        flags.v = (operand >= RLA_W_LO) && (operand < RLA_W_HI);
    end
  end

endmodule

//--- hdl/ssx_wdog_guard.sv
module ssx_wdog_guard
  import ssx_pkg::*;
#(
  // Arbitrary neutral key value
  parameter logic [7:0] WDOG_KEY = 8'hA5
)
(
  // Data memory write port
  input  wire logic        mem_we,
  input  wire logic [15:0] mem_addr,
  input  wire logic [15:0] mem_wdata,
  // Violation pulse
  output logic             violation
);

  // Key sits in the upper byte of the control word
  assign violation = mem_we && (mem_addr == WDOG_CTRL_ADDR) &&
                     (mem_wdata[15:8] != WDOG_KEY);

endmodule

//--- hdl/ssx_exec_unit.sv
module ssx_exec_unit
  import ssx_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Write address channel
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  // Write data channel
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // Write response channel
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // Read address channel
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  // Read data channel
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp
);

  // ----------------------------------------------------------------
  // State and memory
  // ----------------------------------------------------------------
  ssx_state_type q, d;
  logic [15:0]   dmem [DMEM_DEPTH];

  logic          mem_we;
  logic [15:0]   mem_addr;
  logic [15:0]   mem_wdata;
  logic          wd_viol;
  logic [15:0]   tos_word;
  logic [15:0]   tos_next_word;
  logic [15:0]   dst_word;
  logic [15:0]   shift_in;
  logic [15:0]   shift_res;
  ssx_flags_type shift_flags;

  function automatic logic [DMEM_AW-1:0] widx(input logic [15:0] a);
    widx = a[DMEM_AW:1];
  endfunction

  // Byte lane select for byte accesses; odd addresses take the upper byte
  function automatic logic [7:0] byte_sel(input logic [15:0] w,
                                          input logic [15:0] a);
    byte_sel = a[0] ? w[15:8] : w[7:0];
  endfunction

  function automatic logic [15:0] byte_merge(input logic [15:0] w,
                                             input logic [15:0] a,
                                             input logic [7:0]  b);
    byte_merge = a[0] ? {b, w[7:0]} : {w[15:8], b};
  endfunction

  function automatic logic [15:0] strb16(input logic [15:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0]  st);
    strb16 = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
  endfunction

  assign tos_word      = dmem[widx(q.sp)];
  assign tos_next_word = dmem[widx(q.sp + STACK_STEP)];
  assign dst_word      = dmem[widx(q.dst)];
  assign shift_in      = q.dst_reg ? q.src
                         : {8'h00, byte_sel(dst_word, q.dst)} |
                           (q.byte_op ? 16'h0000
                            : {dst_word[15:8], 8'h00});

  ssx_shift_unit u_shift (
    .operand  (shift_in),
    .carry_in (q.sr[SR_C]),
    .byte_op  (q.byte_op),
    .rotate   (q.op == OP_ROL_CARRY),
    .result   (shift_res),
    .flags    (shift_flags)
  );

  ssx_wdog_guard u_wdog (
    .mem_we    (mem_we),
    .mem_addr  (mem_addr),
    .mem_wdata (mem_wdata),
    .violation (wd_viol)
  );

  // ----------------------------------------------------------------
  // Bus handshakes
  // ----------------------------------------------------------------
  assign s_axi_awready = !q.aw_have && !q.bvalid;
  assign s_axi_wready  = !q.w_have && !q.bvalid;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic        wr_go;
    logic [15:0] temp;
    logic [15:0] wr16;
    d         = q;
    wr_go     = 1'b0;
    mem_we    = 1'b0;
    mem_addr  = 16'h0000;
    mem_wdata = 16'h0000;
    temp      = 16'h0000;
    wr16      = 16'h0000;

    // Write channel capture, either order
    if (s_axi_awvalid && s_axi_awready) begin
      d.aw_have = 1'b1;
      d.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      d.w_have = 1'b1;
      d.wdata  = s_axi_wdata;
      d.wstrb  = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready)
      d.bvalid = 1'b0;
    if (q.rvalid && s_axi_rready)
      d.rvalid = 1'b0;

    // Register write
    wr_go = q.aw_have && q.w_have && !q.bvalid;
    if (wr_go) begin
      d.aw_have = 1'b0;
      d.w_have  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = RESP_OKAY;
      if (q.awaddr == REG_CTRL) begin
        if (q.wstrb[0] && !q.busy) begin
          d.op      = ssx_op_type'(q.wdata[CTRL_OP_LSB +: 4]);
          d.byte_op = q.wdata[CTRL_BYTE_BIT];
          d.dst_reg = q.wdata[CTRL_DREG_BIT];
        end
        if (q.wstrb[3] && q.wdata[CTRL_START_BIT] && !q.busy) begin
          d.busy = 1'b1;
          d.done = 1'b0;
          d.cnt  = op_cycles(ssx_op_type'(q.wdata[CTRL_OP_LSB +: 4])) -
                   3'h1;
        end
      end else if (q.awaddr == REG_STATUS) begin
        if (q.wstrb[0] && q.wdata[STAT_DONE_BIT])
          d.done = 1'b0;
        if (q.wstrb[0] && q.wdata[STAT_VIOL_BIT])
          d.viol = 1'b0;
      end else if (q.awaddr == REG_SRC) begin
        d.src = strb16(q.src, q.wdata, q.wstrb);
      end else if (q.awaddr == REG_DST) begin
        d.dst = strb16(q.dst, q.wdata, q.wstrb);
      end else if (q.awaddr == REG_STACK) begin
        d.sp = strb16(q.sp, q.wdata, q.wstrb);
      end else if (q.awaddr == REG_STATUSW) begin
        d.sr = strb16(q.sr, q.wdata, q.wstrb);
      end else if (q.awaddr == REG_PROG) begin
        d.pc = strb16(q.pc, q.wdata, q.wstrb);
      end else if (q.awaddr == REG_RESULT) begin
        d.bresp = RESP_OKAY;
      end else if (q.awaddr == REG_MADDR) begin
        d.maddr = strb16(q.maddr, q.wdata, q.wstrb);
      end else if (q.awaddr == REG_MDATA) begin
        // Memory belongs to the executor while it runs
        if (!q.busy) begin
          mem_we    = 1'b1;
          mem_addr  = q.maddr;
          mem_wdata = strb16(dmem[widx(q.maddr)], q.wdata, q.wstrb);
        end
      end else begin
        d.bresp = RESP_SLVERR;
      end
    end

    // Register read
    if (s_axi_arvalid && s_axi_arready) begin
      d.rvalid = 1'b1;
      d.rresp  = RESP_OKAY;
      d.rdata  = 32'h0000_0000;
      if (s_axi_araddr == REG_CTRL) begin
        d.rdata[CTRL_OP_LSB +: 4] = q.op;
        d.rdata[CTRL_BYTE_BIT]    = q.byte_op;
        d.rdata[CTRL_DREG_BIT]    = q.dst_reg;
      end else if (s_axi_araddr == REG_STATUS) begin
        d.rdata[STAT_BUSY_BIT] = q.busy;
        d.rdata[STAT_DONE_BIT] = q.done;
        d.rdata[STAT_VIOL_BIT] = q.viol;
      end else if (s_axi_araddr == REG_SRC) begin
        d.rdata[15:0] = q.src;
      end else if (s_axi_araddr == REG_DST) begin
        d.rdata[15:0] = q.dst;
      end else if (s_axi_araddr == REG_STACK) begin
        d.rdata[15:0] = q.sp;
      end else if (s_axi_araddr == REG_STATUSW) begin
        d.rdata[15:0] = q.sr;
      end else if (s_axi_araddr == REG_PROG) begin
        d.rdata[15:0] = q.pc;
      end else if (s_axi_araddr == REG_RESULT) begin
        d.rdata[15:0] = q.result;
      end else if (s_axi_araddr == REG_MADDR) begin
        d.rdata[15:0] = q.maddr;
      end else if (s_axi_araddr == REG_MDATA) begin
        d.rdata[15:0] = dmem[widx(q.maddr)];
      end else begin
        d.rresp = RESP_SLVERR;
      end
    end

    // Execution: effects land on the last cycle of the operation
    if (q.busy) begin
      if (q.cnt != 3'h0) begin
        d.cnt = q.cnt - 3'h1;
      end else begin
        d.busy = 1'b0;
        d.done = 1'b1;
        d.pc   = q.pc + {13'h0000, op_words(q.op), 1'b0};
        case (q.op)
          OP_POP: begin
            temp = tos_word;
            d.sp = q.sp + STACK_STEP;
            if (q.dst_reg) begin
              d.result = q.byte_op ? {8'h00, temp[7:0]} : temp;
            end else begin
              mem_we    = 1'b1;
              mem_addr  = q.dst;
              mem_wdata = q.byte_op
                          ? byte_merge(dst_word, q.dst, temp[7:0])
                          : temp;
            end
          end
          OP_PUSH: begin
            wr16      = q.sp - STACK_STEP;
            d.sp      = wr16;
            mem_we    = 1'b1;
            mem_addr  = wr16;
            mem_wdata = q.byte_op
                        ? {dmem[widx(wr16)][15:8], q.src[7:0]}
                        : q.src;
          end
          OP_SUB_EXIT: begin
            d.pc = tos_word;
            d.sp = q.sp + STACK_STEP;
          end
          OP_IRQ_EXIT: begin
            d.sr = tos_word;
            d.pc = tos_next_word;
            d.sp = q.sp + STACK_STEP + STACK_STEP;
          end
          OP_SHL_ARITH, OP_ROL_CARRY: begin
            d.sr[SR_C] = shift_flags.c;
            d.sr[SR_N] = shift_flags.n;
            d.sr[SR_Z] = shift_flags.z;
            d.sr[SR_V] = shift_flags.v;
            if (q.dst_reg) begin
              d.result = shift_res;
            end else begin
              mem_we    = 1'b1;
              mem_addr  = q.dst;
              mem_wdata = q.byte_op
                          ? byte_merge(dst_word, q.dst, shift_res[7:0])
                          : shift_res;
            end
          end
          OP_MOV_XX, OP_MOV_IX, OP_BIC_X: begin
            // Rewrites the word in place; at the watchdog address the stored upper byte acts as the key
            mem_we    = 1'b1;
            mem_addr  = q.dst;
            mem_wdata = dst_word;
          end
          default: begin
            d.cnt = 3'h0;
          end
        endcase
      end
    end

    // Violation is sticky; a new one beats a same-cycle clear
    if (wd_viol)
      d.viol = 1'b1;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // No reset: contents are undefined until software loads them
  always_ff @(posedge aclk) begin
    if (mem_we) begin
      dmem[widx(mem_addr)] <= mem_wdata;
    end
  end

endmodule

//--- dv/ssx_exec_chk.sv
module ssx_exec_chk
  import ssx_pkg::*;
(
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Write side
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  // Read side
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp
);
  // ---------------
  // Bus handshakes
  // ---------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("no bvalid");
  a_b_holds: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_b_release: assert property (s_axi_bvalid && s_axi_bready
    |=> !s_axi_bvalid) else $error("bvalid stuck");
  a_aw_block: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready) else $error("write not refused");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("no rvalid");
  a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("r moved");
  a_r_release: assert property (s_axi_rvalid && s_axi_rready
    |=> !s_axi_rvalid) else $error("rvalid stuck");
  a_ar_block: assert property (s_axi_arready != s_axi_rvalid)
    else $error("arready wrong");
  a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR
    |-> s_axi_rdata == 32'h0) else $error("error read not zero");
  a_resp_code: assert property (s_axi_bvalid |-> s_axi_bresp == RESP_OKAY ||
    s_axi_bresp == RESP_SLVERR) else $error("bad bresp");

  c_write: cover property (s_axi_awvalid && s_axi_awready && s_axi_wvalid);
  c_rd_err: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
  c_b_stall: cover property (s_axi_bvalid && !s_axi_bready);
endmodule

bind ssx_exec_unit ssx_exec_chk ssx_exec_chk_inst (
  .aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp)
);

//--- dv/test_stack_and_shift_exec_unit.sv
module test_stack_and_shift_exec_unit
  import ssx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        aclk, awr, wrd, bv, arr, rv;
  logic        aresetn = 1'b0, awv = 1'b0, wv = 1'b0, brdy = 1'b0;
  logic        arv = 1'b0, rrdy = 1'b0;
  logic [7:0]  awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rdat;
  logic [1:0]  bresp, rresp;
  int          num_errors = 0, tests_run = 0;
  ssx_op_type  nop_op [6] = '{OP_MOV_XX, OP_MOV_IX, OP_BIC_X, OP_JMP_NEXT,
                              OP_BIC_R, OP_IDLE};
  logic [31:0] nop_w [6] = '{3, 2, 2, 1, 1, 1};
  int          nop_c [6] = '{6, 5, 4, 2, 1, 1};
  logic [15:0] sh_in [9] = '{16'h3FFF, 16'h4000, 16'hBFFF, 16'hC000,
                   16'h8000, 16'hAB3F, 16'h5540, 16'h12BF, 16'hFFC0};

  ssx_exec_unit ssx_exec_unit_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_awprot(3'h0),
    .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_bvalid(bv), .s_axi_bready(brdy),
    .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_rvalid(rv),
    .s_axi_rready(rrdy), .s_axi_rdata(rdat), .s_axi_rresp(rresp)
  );

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // ---------------
  // Bus tasks
  // ---------------
  task automatic close_out;
    if (num_errors == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic hang(input string nm);
    num_errors++;
    $display("[ERR] %s expected answer seen none", nm);
    close_out();
  endtask

  // Ready sampled at the falling edge, so it is settled before the
  // rising edge that takes the item; release happens on that edge.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = RESP_OKAY);
    logic       ah, wh, bs;
    logic [1:0] r;
    @(posedge aclk);
    awv <= 1'b1;
    awa <= a;
    wv <= 1'b1;
    wd <= d;
    bs = 1'b0;
    for (int n = 0; n < 64 && !bs; n++) begin
      @(negedge aclk);
      ah = awv && awr;
      wh = wv && wrd;
      bs = bv && brdy;
      r = bresp;
      @(posedge aclk);
      if (ah) awv <= 1'b0;
      if (wh) wv <= 1'b0;
      brdy <= bv && !bs;
    end
    if (!bs) hang("bresp");
    chk("bresp", {30'h0, r}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    input logic [1:0] er = RESP_OKAY);
    logic       ah, rs;
    logic [1:0] r;
    @(posedge aclk);
    arv <= 1'b1;
    ara <= a;
    rs = 1'b0;
    for (int n = 0; n < 64 && !rs; n++) begin
      @(negedge aclk);
      ah = arv && arr;
      rs = rv && rrdy;
      d = rdat;
      r = rresp;
      @(posedge aclk);
      if (ah) arv <= 1'b0;
      rrdy <= rv && !rs;
    end
    if (!rs) hang("rresp");
    chk("rresp", {30'h0, r}, {30'h0, er});
  endtask

  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(nm, d, exp);
  endtask

  task automatic mset(input logic [15:0] a, d);
    wr(REG_MADDR, {16'h0, a});
    wr(REG_MDATA, {16'h0, d});
  endtask

  task automatic mchk(input logic [15:0] a, input logic [31:0] exp);
    wr(REG_MADDR, {16'h0, a});
    rdc("mem", REG_MDATA, exp);
  endtask

  task automatic run(input ssx_op_type op, input logic byt, dreg,
                     input int nc = 0, input logic late = 1'b0);
    logic [31:0] s;
    // Probe samples the last busy edge, or the edge after it when late
    fork
      wr(REG_CTRL, {1'b1, 25'h0, dreg, byt, op});
      if (nc > 0) begin
        repeat (nc + 1 + late) @(posedge aclk);
        rdc("cycles", REG_STATUS, late ? 32'h2 : 32'h1);
      end
    join
    s = 32'h0;
    for (int n = 0; n < 16 && !s[STAT_DONE_BIT]; n++)
      rd(REG_STATUS, s);
    if (!s[STAT_DONE_BIT]) hang("done");
    wr(REG_STATUS, 32'h2);
  endtask

  // Mode bits 5..3 preset high so any disturbance shows
  function automatic void shx(input logic rot, byt, c,
      input logic [15:0] x, output logic [31:0] r, f);
    r = byt ? {24'h0, x[6:0], rot & c} : {16'h0, x[14:0], rot & c};
    f = 32'h0038;
    f[SR_C] = byt ? x[7] : x[15];
    f[SR_Z] = r == 32'h0;
    f[SR_N] = byt ? r[7] : r[15];
    f[SR_V] = byt ? (x[7:0] >= 8'h40 && x[7:0] < 8'hC0)
                  : (x >= 16'h4000 && x < 16'hC000);
  endfunction

  // ---------------
  // Scenarios
  // ---------------
  initial begin
    logic [31:0] d, er, ef;
    logic        c;
    int          k;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rdc("sp", REG_STACK, 32'h0);
    rdc("pc", REG_PROG, 32'h0);
    rd(8'h40, d, RESP_SLVERR);
    chk("rdata", d, 32'h0);
    wr(8'h40, 32'h1, RESP_SLVERR);
    wr(REG_RESULT, 32'hFFFF);
    rdc("result", REG_RESULT, 32'h0);
    wr(REG_STATUSW, 32'h013F);
    wr(REG_STACK, 32'h0020);
    wr(REG_SRC, 32'h1234);
    run(OP_PUSH, 1'b0, 1'b0);
    rdc("sp", REG_STACK, 32'h001E);
    mchk(16'h001E, 32'h1234);
    run(OP_POP, 1'b0, 1'b1);
    rdc("result", REG_RESULT, 32'h1234);
    rdc("sp", REG_STACK, 32'h0020);
    mset(16'h0020, 16'hABCD);
    run(OP_POP, 1'b1, 1'b1);
    rdc("result", REG_RESULT, 32'h00CD);
    rdc("sp", REG_STACK, 32'h0022);
    wr(REG_SRC, 32'h55AA);
    run(OP_PUSH, 1'b1, 1'b0);
    rdc("sp", REG_STACK, 32'h0020);
    mchk(16'h0020, 32'hABAA);
    mset(16'h0030, 16'h4444);
    wr(REG_STACK, 32'h0030);
    run(OP_SUB_EXIT, 1'b0, 1'b0);
    rdc("pc", REG_PROG, 32'h4444);
    rdc("sp", REG_STACK, 32'h0032);
    rdc("sr", REG_STATUSW, 32'h013F);
    wr(REG_STATUSW, 32'h0);
    mset(16'h0040, 16'h013F);
    mset(16'h0042, 16'h8888);
    wr(REG_STACK, 32'h0040);
    run(OP_IRQ_EXIT, 1'b0, 1'b0);
    rdc("sr", REG_STATUSW, 32'h013F);
    rdc("pc", REG_PROG, 32'h8888);
    rdc("sp", REG_STACK, 32'h0044);
    for (int i = 0; i < 12; i++) begin
      k = i / 2;
      mset(16'h0050, 16'h2468);
      wr(REG_DST, 32'h0050);
      wr(REG_PROG, 32'h0100);
      wr(REG_STACK, 32'h0060);
      run(nop_op[k], 1'b0, 1'b0, nop_c[k], i[0]);
      d = 32'h0100 + (nop_w[k] << 1);
      rdc("pc", REG_PROG, d);
      rdc("sp", REG_STACK, 32'h0060);
      rdc("sr", REG_STATUSW, 32'h013F);
      mchk(16'h0050, 32'h2468);
    end
    // Word 0x0020 aliases 0x0120, so it can be loaded without the key
    mset(16'h0020, 16'h1234);
    wr(REG_DST, 32'h0120);
    run(OP_MOV_XX, 1'b0, 1'b0);
    rdc("status", REG_STATUS, 32'h0004);
    wr(REG_STATUS, 32'h0004);
    mset(16'h0120, 16'hA512);
    run(OP_MOV_XX, 1'b0, 1'b0);
    rdc("status", REG_STATUS, 32'h0000);
    // Byte pop into the upper lane, then a word shift in memory
    mset(16'h0070, 16'h77EE);
    mset(16'h0062, 16'h1122);
    wr(REG_STACK, 32'h0070);
    wr(REG_DST, 32'h0063);
    run(OP_POP, 1'b1, 1'b0);
    mchk(16'h0062, 32'hEE22);
    rdc("sp", REG_STACK, 32'h0072);
    wr(REG_DST, 32'h0062);
    run(OP_SHL_ARITH, 1'b0, 1'b0);
    mchk(16'h0062, 32'hDC44);
    for (int i = 0; i < 36; i++) begin
      c = i[2];
      shx(i[0], i[1], c, sh_in[i / 4], er, ef);
      wr(REG_STATUSW, {26'h0, 3'h7, 2'h0, c});
      wr(REG_SRC, {16'h0, sh_in[i / 4]});
      run(i[0] ? OP_ROL_CARRY : OP_SHL_ARITH, i[1], 1'b1);
      rdc("result", REG_RESULT, er);
      rdc("flags", REG_STATUSW, ef);
    end
    close_out();
  end
endmodule
